//--- verilog/hbmp_pkg.sv
// Shared constants for the host bus and media pin blocks
package hbmp_pkg;
  // Device register index on the 8-bit host port
  localparam logic [2:0] REG_STAT = 3'h0;
  localparam logic [2:0] REG_MASK = 3'h1;
  localparam logic [2:0] REG_CTRL = 3'h2;
  localparam logic [2:0] REG_TXD  = 3'h3;
  // Control register fields
  localparam int CTRL_BP = 0;
  localparam int CTRL_OD = 1;
  // Sticky status bits
  localparam int ST_TXDONE = 0;
  localparam int ST_RXACT  = 1;
  localparam int ST_CORE   = 2;
  // Cycles after reset release before straps are taken
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // Host controller AHB word index
  localparam logic [1:0] HREG_CMD  = 2'h0;
  localparam logic [1:0] HREG_STAT = 2'h1;
  // Command word fields
  localparam int CMD_ADDR_LO = 0;
  localparam int CMD_RD      = 8;
  localparam int CMD_WD_LO   = 16;
  // Host pin phase lengths in cycles
  localparam logic [3:0] PH_CYC   = 4'h4;
  localparam logic [3:0] STRB_CYC = 4'h8;
  // Transmit state
  typedef enum logic {
    HBMP_TX_IDLE = 1'b0,
    HBMP_TX_SEND = 1'b1
  } hbmp_tx_t;
  // Host access sequencer, Gray along the multiplexed path
  typedef enum logic [2:0] {
    HBMP_H_IDLE  = 3'b000,
    HBMP_H_ALE   = 3'b001,
    HBMP_H_LATCH = 3'b011,
    HBMP_H_SETUP = 3'b010,
    HBMP_H_STRB  = 3'b110,
    HBMP_H_HOLD  = 3'b100
  } hbmp_hst_t;
endpackage

//--- verilog/hbmp_if.sv
// Pin bundle joining the host controller and the device, with pull-ups
interface hbmp_if;
  logic       hcs_n;
  logic       hrd;
  logic       hwr;
  logic [2:0] ha;
  logic       ha1_oe;
  logic [7:0] hd_o;
  logic       hd_oe;
  logic [7:0] dd_o;
  logic       dd_oe;
  logic       irq_n;
  logic       pa_o;
  logic       pa_oe;
  logic       pb_o;
  logic       pb_oe;
  logic       pb_strap_gnd;
  logic       txen;
  logic       rx;
  logic       a1;
  logic [7:0] data;
  logic       pa;
  logic       pb;
  // Wire levels; undriven pins float high through pull-ups, pb low when its strap is grounded
  assign a1   = ha1_oe ? ha[1] : 1'b1;
  assign data = dd_oe ? dd_o : (hd_oe ? hd_o : 8'hFF);
  assign pa   = pa_oe ? pa_o : 1'b1;
  assign pb   = pb_oe ? pb_o : ~pb_strap_gnd;
  modport dev (
    input  hcs_n, hrd, hwr, ha, a1, data, rx, pb,
    output dd_o, dd_oe, irq_n, pa_o, pa_oe, pb_o, pb_oe, txen
  );
  modport host (
    input  data, irq_n,
    output hcs_n, hrd, hwr, ha, ha1_oe, hd_o, hd_oe
  );
endinterface

//--- verilog/hbmp_sync.sv
// Two-stage synchroniser for a bundle of pin levels
module hbmp_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hbmp_sync_t;
  hbmp_sync_t s_r;
  hbmp_sync_t s_nxt;

  // First stage feeds only the second
  always_comb begin
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= {INIT, INIT};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.s2;
endmodule

//--- verilog/hbmp_dev.sv
// Device end: 8-bit host port decoder and line-side pulse interface
//
// Function
// - Non-mux address from three pins, pin0 LSB
// - Low strap pin selects multiplexed bus mode
// - Mux mode latches address from low lines
// - Upper data lines carry data only
// - Host data strobe times each transfer
// - Direction high reads, low writes
// - Read strobe makes device drive data
// - Write strobe low while selected stores data
// - Strobes ignored without chip select
// - Reset input low fully resets device
// - Enabled interrupt condition drives interrupt low
// - Normal mode sends two-pulse encoded data
// - Backplane pulse A push-pull or open-drain
// - Backplane pulse B gives double-rate clock
// - Pulse B strap sets enable polarity
// - Active-high enable only in backplane mode
// - Driver enable asserted during own transmission
// - Received line data from receive input
// - Interrupt only for masked-in status bits
module hbmp_dev #(
  parameter int BIT_CYC = 20
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  hbmp_if.dev       bus,
  input  wire logic core_event,
  output logic      tx_busy
);
  localparam int PW = $clog2(BIT_CYC);
  localparam logic [PW-1:0] PH_LAST = PW'(BIT_CYC - 1);
  localparam logic [PW-1:0] QTR     = PW'(BIT_CYC / 4);
  localparam logic [PW-1:0] HALF    = PW'(BIT_CYC / 2);
  localparam logic [PW-1:0] QTR_M1  = PW'(BIT_CYC / 4 - 1);

  generate
    if (BIT_CYC < 8 || BIT_CYC % 4 != 0) begin : g_bad
      $error("BIT_CYC must be a multiple of 4, at least 8");
    end
  endgenerate

  typedef struct packed {
    logic [1:0]       strap_cnt;
    logic             strap_done;
    logic             mux;
    logic             pb_gnd;
    logic             st68;
    logic [2:0]       addr;
    logic             ale_q;
    logic             rd_q;
    logic             wr_q;
    logic             rx_q;
    logic [2:0]       sticky;
    logic [2:0]       mask;
    logic [1:0]       ctrl;
    logic [7:0]       txd;
    hbmp_pkg::hbmp_tx_t tx;
    logic [2:0]       bitn;
    logic [PW-1:0]    ph;
    logic [PW-1:0]    ck;
    logic             bclk;
    logic [7:0]       d_o;
    logic             d_oe;
    logic             irq_n;
    logic             pa_o;
    logic             pa_oe;
    logic             pb_o;
    logic             pb_oe;
    logic             txen;
  } hbmp_dev_t;

  hbmp_dev_t s_r;
  hbmp_dev_t s_nxt;

  logic [15:0] pin_q;
  logic        cs_n;
  logic        rdp;
  logic        wrp;
  logic [2:0]  ap;
  logic [7:0]  din;
  logic        rxl;
  logic        pbl;
  logic        sel;
  logic        rd_act;
  logic        wr_go;
  logic        rx_rise;
  logic        pol_hi;
  logic        bit1;
  logic        av;
  logic        done;
  logic [2:0]  ra;
  logic [2:0]  clr;
  logic [7:0]  rv;

  // All host and line pins pass two flops before use
  hbmp_sync #(
    .W    (16),
    .INIT (16'hFFFF)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({bus.hcs_n, bus.hrd, bus.hwr, bus.ha[2], bus.a1, bus.ha[0],
               bus.data, bus.rx, bus.pb}),
    .q       (pin_q)
  );

  assign {cs_n, rdp, wrp, ap, din, rxl, pbl} = pin_q;

  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    done  = 1'b0;
    clr   = 3'h0;
    sel   = ~cs_n & s_r.strap_done;
    rd_act  = sel & ~rdp & wrp;
    wr_go   = (sel & ~s_r.st68 & ~s_r.wr_q & wrp & rdp)
            | (sel & ~s_r.rd_q & rdp & ~wrp);
    rx_rise = ~s_r.rx_q & rxl;
    ra      = s_r.mux ? s_r.addr : ap;
    pol_hi  = s_r.pb_gnd & s_r.ctrl[hbmp_pkg::CTRL_BP];
    s_nxt.ale_q = ap[2];
    s_nxt.rd_q  = rdp;
    s_nxt.wr_q  = wrp;
    s_nxt.rx_q  = rxl;
    // Straps taken once the synchronisers hold real pin levels
    if (!s_r.strap_done) begin
      s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
      if (s_r.strap_cnt == hbmp_pkg::STRAP_WAIT) begin
        s_nxt.strap_done = 1'b1;
        s_nxt.mux        = ~ap[0];
        s_nxt.pb_gnd     = ~pbl;
      end
    end
    // Both strobe pins low only happens on a strobe-plus-direction bus
    if (sel & ~rdp & ~wrp) begin
      s_nxt.st68 = 1'b1;
    end
    // Address latched on the falling latch strobe and held after
    if (s_r.mux & s_r.ale_q & ~ap[2]) begin
      s_nxt.addr = din[2:0];
    end
    // Register read value, all eight lines carry data
    case (ra)
      hbmp_pkg::REG_STAT: rv = {pol_hi, s_r.st68, s_r.mux, s_r.rx_q,
                                logic'(s_r.tx), s_r.sticky};
      hbmp_pkg::REG_MASK: rv = {5'h00, s_r.mask};
      hbmp_pkg::REG_CTRL: rv = {6'h00, s_r.ctrl};
      hbmp_pkg::REG_TXD:  rv = s_r.txd;
      default:            rv = 8'h00;
    endcase
    s_nxt.d_o  = rv;
    s_nxt.d_oe = rd_act;
    // Register write at the trailing edge of the strobe
    if (wr_go) begin
      case (ra)
        hbmp_pkg::REG_STAT: clr = din[2:0];
        hbmp_pkg::REG_MASK: s_nxt.mask = din[2:0];
        hbmp_pkg::REG_CTRL: s_nxt.ctrl = din[1:0];
        hbmp_pkg::REG_TXD: begin
          if (s_r.tx == hbmp_pkg::HBMP_TX_IDLE) begin
            s_nxt.txd  = din;
            s_nxt.tx   = hbmp_pkg::HBMP_TX_SEND;
            s_nxt.bitn = 3'h0;
            s_nxt.ph   = '0;
          end
        end
        default: ;
      endcase
    end
    // Serialise LSB first, one bit per BIT_CYC cycles
    if (s_r.tx == hbmp_pkg::HBMP_TX_SEND) begin
      if (s_r.ph == PH_LAST) begin
        s_nxt.ph   = '0;
        s_nxt.txd  = {1'b0, s_r.txd[7:1]};
        s_nxt.bitn = s_r.bitn + 3'h1;
        if (s_r.bitn == 3'h7) begin
          s_nxt.tx = hbmp_pkg::HBMP_TX_IDLE;
          done     = 1'b1;
        end
      end else begin
        s_nxt.ph = s_r.ph + 1'b1;
      end
    end
    // Sticky events; a set in the clearing cycle wins
    s_nxt.sticky = (s_r.sticky & ~clr)
                 | {core_event, rx_rise, done};
    s_nxt.irq_n  = ~|(s_nxt.sticky & s_nxt.mask);
    // Backplane clock, period half a bit; parked high in normal mode so
    // entering backplane mode never gives a short first low phase
    if (!s_r.ctrl[hbmp_pkg::CTRL_BP]) begin
      s_nxt.ck   = '0;
      s_nxt.bclk = 1'b1;
    end else if (s_r.ck == QTR_M1) begin
      s_nxt.ck   = '0;
      s_nxt.bclk = ~s_r.bclk;
    end else begin
      s_nxt.ck = s_r.ck + 1'b1;
    end
    // In normal mode a one bit gives pulse A then pulse B, each a quarter bit
    bit1 = (s_r.tx == hbmp_pkg::HBMP_TX_SEND) & s_r.txd[0];
    if (s_r.ctrl[hbmp_pkg::CTRL_BP]) begin
      av          = ~bit1;
      s_nxt.pb_o  = s_r.bclk;
    end else begin
      av          = ~(bit1 & (s_r.ph < QTR));
      s_nxt.pb_o  = ~(bit1 & (s_r.ph >= QTR) & (s_r.ph < HALF));
    end
    s_nxt.pa_o  = av;
    // Open-drain drives only the low level, pull-up does the rest
    s_nxt.pa_oe = s_r.strap_done
                & ~(s_r.ctrl[hbmp_pkg::CTRL_BP]
                    & s_r.ctrl[hbmp_pkg::CTRL_OD] & av);
    s_nxt.pb_oe = s_r.strap_done;
    s_nxt.txen  = (s_r.tx == hbmp_pkg::HBMP_TX_SEND) ? pol_hi
                                                     : ~pol_hi;
  end

  // State register, cleared on reset except the idle-high levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r       <= '0;
      s_r.rd_q  <= 1'b1;
      s_r.wr_q  <= 1'b1;
      s_r.rx_q  <= 1'b1;                 // Matches synchroniser reset level
      s_r.irq_n <= 1'b1;
      s_r.pa_o  <= 1'b1;
      s_r.pb_o  <= 1'b1;
      s_r.txen  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Pin drivers straight from the state register
  assign bus.dd_o  = s_r.d_o;
  assign bus.dd_oe = s_r.d_oe;
  assign bus.irq_n = s_r.irq_n;
  assign bus.pa_o  = s_r.pa_o;
  assign bus.pa_oe = s_r.pa_oe;
  assign bus.pb_o  = s_r.pb_o;
  assign bus.pb_oe = s_r.pb_oe;
  assign bus.txen  = s_r.txen;
  assign tx_busy   = logic'(s_r.tx);
endmodule

//--- verilog/hbmp_host.sv
// Host end: AHB-Lite command registers driving the 8-bit device port
module hbmp_host #(
  parameter bit MUX_BUS = 1'b0,
  parameter bit STYLE68 = 1'b0
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  hbmp_if.host             bus
);
  typedef struct packed {
    logic [2:0]           addr;
    logic                 rd;
    logic [7:0]           wd;
    logic [7:0]           rdat;
    hbmp_pkg::hbmp_hst_t  st;
    logic [3:0]           cnt;
    logic                 dv;
    logic                 dw;
    logic [1:0]           da;
    logic [31:0]          hrdata;
    logic                 rdy;
    logic                 cs_n;
    logic                 rdp;
    logic                 wrp;
    logic [2:0]           a;
    logic                 a1_oe;
    logic [7:0]           d_o;
    logic                 d_oe;
  } hbmp_host_t;

  hbmp_host_t s_r;
  hbmp_host_t s_nxt;
  logic [8:0] pin_q;
  logic       adr_ph;
  logic       busy;
  logic       strb;
  logic       last;

  // Device data and interrupt pins pass two flops
  hbmp_sync #(
    .W    (9),
    .INIT (9'h1FF)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({bus.irq_n, bus.data}),
    .q       (pin_q)
  );

  // Bus slave, sequencer and pin levels
  always_comb begin
    s_nxt  = s_r;
    busy   = s_r.st != hbmp_pkg::HBMP_H_IDLE;
    adr_ph = hsel & hready & htrans[1];
    s_nxt.dv = adr_ph;
    s_nxt.dw = hwrite;
    s_nxt.da = haddr[3:2];
    if (adr_ph & ~hwrite) begin
      s_nxt.hrdata = (haddr[3:2] == hbmp_pkg::HREG_STAT)
                   ? {16'h0000, s_r.rdat, 6'h00, ~pin_q[8], busy}
                   : 32'h0000_0000;
    end
    last = s_r.cnt == ((s_r.st == hbmp_pkg::HBMP_H_STRB)
                       ? hbmp_pkg::STRB_CYC - 4'h1
                       : hbmp_pkg::PH_CYC - 4'h1);
    if (busy) begin
      s_nxt.cnt = last ? 4'h0 : s_r.cnt + 4'h1;
    end
    // Command taken only while idle; later ones are dropped
    if (s_r.dv & s_r.dw & (s_r.da == hbmp_pkg::HREG_CMD) & ~busy) begin
      s_nxt.addr = hwdata[hbmp_pkg::CMD_ADDR_LO +: 3];
      s_nxt.rd   = hwdata[hbmp_pkg::CMD_RD];
      s_nxt.wd   = hwdata[hbmp_pkg::CMD_WD_LO +: 8];
      s_nxt.st   = MUX_BUS ? hbmp_pkg::HBMP_H_ALE : hbmp_pkg::HBMP_H_SETUP;
      s_nxt.cnt  = 4'h0;
    end else if (busy & last) begin
      unique case (s_r.st)
        hbmp_pkg::HBMP_H_ALE:   s_nxt.st = hbmp_pkg::HBMP_H_LATCH;
        hbmp_pkg::HBMP_H_LATCH: s_nxt.st = hbmp_pkg::HBMP_H_SETUP;
        hbmp_pkg::HBMP_H_SETUP: s_nxt.st = hbmp_pkg::HBMP_H_STRB;
        hbmp_pkg::HBMP_H_STRB: begin
          s_nxt.st = hbmp_pkg::HBMP_H_HOLD;
          if (s_r.rd) begin
            s_nxt.rdat = pin_q[7:0];
          end
        end
        hbmp_pkg::HBMP_H_HOLD:  s_nxt.st = hbmp_pkg::HBMP_H_IDLE;
        default:                s_nxt.st = hbmp_pkg::HBMP_H_IDLE;
      endcase
    end
    // Pin levels follow the next state
    strb       = s_nxt.st == hbmp_pkg::HBMP_H_STRB;
    s_nxt.cs_n = ~(s_nxt.st[1] | (s_nxt.st == hbmp_pkg::HBMP_H_HOLD));
    if (s_nxt.st == hbmp_pkg::HBMP_H_ALE
        || s_nxt.st == hbmp_pkg::HBMP_H_LATCH) begin
      s_nxt.d_o  = {5'h00, s_nxt.addr};
      s_nxt.d_oe = 1'b1;
    end else begin
      s_nxt.d_o  = s_nxt.wd;
      s_nxt.d_oe = ~s_nxt.cs_n & ~s_nxt.rd;
    end
    // Idle non-mux address rests high so the mux strap reads open
    s_nxt.a     = MUX_BUS ? {s_nxt.st == hbmp_pkg::HBMP_H_ALE, 2'b10}
                          : (s_nxt.cs_n ? 3'h7 : s_nxt.addr);
    s_nxt.a1_oe = ~MUX_BUS;
    if (STYLE68) begin
      s_nxt.rdp = ~strb;
      s_nxt.wrp = s_nxt.cs_n | s_nxt.rd;
    end else begin
      s_nxt.rdp = ~(strb & s_nxt.rd);
      s_nxt.wrp = ~(strb & ~s_nxt.rd);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r       <= '0;
      s_r.rdy   <= 1'b1;
      s_r.cs_n  <= 1'b1;
      s_r.rdp   <= 1'b1;
      s_r.wrp   <= 1'b1;
      s_r.a     <= {2'b11, ~MUX_BUS};
      s_r.a1_oe <= ~MUX_BUS;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout  = s_r.rdy;
  assign hresp      = 1'b0;
  assign hrdata     = s_r.hrdata;
  assign bus.hcs_n  = s_r.cs_n;
  assign bus.hrd    = s_r.rdp;
  assign bus.hwr    = s_r.wrp;
  assign bus.ha     = s_r.a;
  assign bus.ha1_oe = s_r.a1_oe;
  assign bus.hd_o   = s_r.d_o;
  assign bus.hd_oe  = s_r.d_oe;
endmodule

//--- verilog/hbmp_host_fix.sv
// Holds no logic; the host end lives in hbmp_host.sv

//--- testbench/hbmp_monitor.sv
// Checker for the pin bundle between the host and device ends
module hbmp_monitor (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hcs_n,
  input wire logic       hrd,
  input wire logic       hwr,
  input wire logic [2:0] ha,
  input wire logic       ha1_oe,
  input wire logic       hd_oe,
  input wire logic       dd_oe,
  input wire logic [7:0] data,
  input wire logic       pa,
  input wire logic       pb,
  input wire logic       pb_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mon_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Read request held by a selected host
  sequence rd_req_s;
    (!hcs_n && !hrd && hwr) [*5];
  endsequence
  // Low half of a pulse B cycle, then back high
  sequence pb_low_s;
    (!pb && pb_oe) [*5] ##1 pb;
  endsequence
  // Data line ownership and strobe framing
  no_clash_a: assert property (!(dd_oe && hd_oe))
    else $error("both ends drive the data lines");
  unsel_quiet_a: assert property (hcs_n [*5] |-> !dd_oe)
    else $error("device drives data while not selected");
  strobe_sel_a: assert property (!hrd |-> !hcs_n)
    else $error("strobe outside chip select");
  read_drive_a: assert property (rd_req_s |-> dd_oe)
    else $error("device silent during read strobe");
  read_release_a: assert property ($rose(hrd) |-> ##5 !dd_oe)
    else $error("device still drives after read");
  write_data_a: assert property ((!hcs_n && !hrd && !hwr) |->
    hd_oe && $stable(data))
    else $error("write data not held during strobe");
  // Multiplexed addressing
  latch_hold_a: assert property ($fell(ha[2]) |-> $stable(data[2:0]))
    else $error("address moved at latch edge");
  mux_strap_a: assert property (!ha[0] && !ha1_oe)
    else $error("mux strap or middle address driven");
  // Line pulse shapes
  pa_pulse_a: assert property ($fell(pa) |-> (!pa) [*5])
    else $error("pulse A shorter than five cycles");
  pb_clock_a: assert property ($fell(pb) && pb_oe |-> pb_low_s)
    else $error("pulse B low phase not five cycles");
endmodule

//--- testbench/tb_host_bus_and_media_pins.sv
// Bench joining host and device ends, driven over AHB-Lite
module tb_host_bus_and_media_pins;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0] v;
    logic [7:0] m;
  } hbmp_note_t;
  logic        hclk       = 1'h0;
  logic        hresetn    = 1'h0;
  logic        hsel       = 1'h0;
  logic [31:0] haddr      = 32'h0;
  logic [1:0]  htrans     = 2'h0;
  logic        hwrite     = 1'h0;
  logic [2:0]  hsize      = 3'h0;
  logic [31:0] hwdata     = 32'h0;
  logic        core_event = 1'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic        tx_busy;
  int          err_total  = 0;
  int          cmp_count  = 0;
  int          od_hi;
  hbmp_note_t  exp_q[$];
  hbmp_note_t  cur_n;
  logic [7:0]  res_r;
  event        res_ev;
  logic        pa_q[$];
  logic        pb_q[$];
  logic        te_q[$];

  hbmp_if hbmp_if_i ();
  hbmp_dev #(.BIT_CYC(20)) hbmp_dev_i (.hclk(hclk), .hresetn(hresetn),
    .bus(hbmp_if_i.dev), .core_event(core_event), .tx_busy(tx_busy));
  hbmp_host #(.MUX_BUS(1'h1), .STYLE68(1'h1)) hbmp_host_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(), .hrdata(hrdata), .bus(hbmp_if_i.host));
  hbmp_monitor hbmp_monitor_i (.hclk(hclk), .hresetn(hresetn),
    .hcs_n(hbmp_if_i.hcs_n), .hrd(hbmp_if_i.hrd), .hwr(hbmp_if_i.hwr),
    .ha(hbmp_if_i.ha), .ha1_oe(hbmp_if_i.ha1_oe), .hd_oe(hbmp_if_i.hd_oe),
    .dd_oe(hbmp_if_i.dd_oe), .data(hbmp_if_i.data), .pa(hbmp_if_i.pa),
    .pb(hbmp_if_i.pb), .pb_oe(hbmp_if_i.pb_oe));

  // 50 MHz clock
  always #10 hclk = ~hclk;

  // Pin trace while a byte is on the line
  always @(posedge hclk) begin
    if (tx_busy === 1'h1) begin
      pa_q.push_back(hbmp_if_i.pa);
      pb_q.push_back(hbmp_if_i.pb);
      te_q.push_back(hbmp_if_i.txen);
      if (hbmp_if_i.pa_oe === 1'h1 && hbmp_if_i.pa_o === 1'h1) od_hi++;
    end
  end

  // Oldest expectation against each reported result
  always @(res_ev) begin
    cur_n = exp_q.pop_front();
    cmp_byte(res_r, cur_n.v, cur_n.m);
  end

  task automatic cmp_byte(input logic [7:0] g, e, m);
    cmp_count++;
    if ((g & m) !== (e & m)) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Note the expectation, then report the observed value
  task automatic chk(input logic [7:0] e, m, g);
    exp_q.push_back('{e, m});
    res_r = g;
    -> res_ev;
    #1;
  endtask

  // One single AHB-Lite word transfer
  task automatic ahb(input logic w, input logic [31:0] a, wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'h1;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask

  // Device register access through the command word, then poll
  task automatic dev(input logic rd, input logic [2:0] a,
                     input logic [7:0] wd, output logic [7:0] q);
    logic [31:0] t;
    ahb(1'h1, 32'h0, {8'h00, wd, 7'h00, rd, 5'h00, a}, t);
    repeat (2) @(posedge hclk);
    do ahb(1'h0, 32'h4, 32'h0, t); while (t[0] !== 1'h0);
    q = t[15:8];
  endtask

  task automatic do_reset(input logic gnd);
    @(posedge hclk);
    hresetn <= 1'h0;
    hbmp_if_i.pb_strap_gnd <= gnd;
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (8) @(posedge hclk);
  endtask

  // Send one byte and rebuild it from the traced pulses
  task automatic tx(input logic [7:0] b, input logic bp, od, pol);
    logic [7:0] rp;
    logic [7:0] rb;
    logic [7:0] q;
    int         f = -1;
    int         lows = 0;
    int         n = 0;
    pa_q.delete();
    pb_q.delete();
    te_q.delete();
    od_hi = 0;
    dev(1'h0, hbmp_pkg::REG_TXD, b, q);
    while (tx_busy !== 1'h0 && n < 1000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 1000) err_total++;
    @(posedge hclk);
    foreach (pa_q[i]) begin
      if (pa_q[i] === 1'h0 && f < 0) f = i;
      if (pa_q[i] === 1'h0) lows++;
    end
    for (int i = 0; i < 8; i++) begin
      rp[i] = ~pa_q[f + 20 * i];
      rb[i] = ~pb_q[f + 20 * i + 5];
    end
    chk(b, 8'hFF, rp);
    if (!bp) chk(b, 8'hFF, rb);
    if (!bp) chk(8'(5 * $countones(b)), 8'hFF, 8'(lows));
    if (bp) chk({7'h0, ~od}, 8'h01, {7'h0, od_hi != 0});
    chk({7'h0, pol}, 8'h01, {7'h0, te_q[f]});
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    close_out();
  end

  // Main sequence
  initial begin
    logic [7:0] q;
    logic [7:0] v;
    logic       p;
    int         n;
    hbmp_if_i.rx = 1'h0;
    hbmp_if_i.pb_strap_gnd = 1'h0;
    void'($urandom(32'h14B8));
    do_reset(1'h0);
    chk(8'h07, 8'h0F, {4'h0, hbmp_if_i.dd_oe, hbmp_if_i.pa,
      hbmp_if_i.txen, hbmp_if_i.irq_n});
    $display("test reset done");
    // Round trips to two registers with distinct values
    repeat (4) begin
      v = 8'($urandom);
      dev(1'h0, hbmp_pkg::REG_MASK, v, q);
      dev(1'h0, hbmp_pkg::REG_CTRL, {6'h00, ~v[1], 1'h0}, q);
      dev(1'h1, hbmp_pkg::REG_MASK, 8'h00, q);
      chk(v, 8'h07, q);
      dev(1'h1, hbmp_pkg::REG_CTRL, 8'h00, q);
      chk({6'h00, ~v[1], 1'h0}, 8'h03, q);
    end
    dev(1'h0, hbmp_pkg::REG_CTRL, 8'h00, q);
    // Status reports straps, detected style and receive level
    dev(1'h1, hbmp_pkg::REG_STAT, 8'h00, q);
    chk(8'h60, 8'hFF, q);
    @(posedge hclk) hbmp_if_i.rx <= 1'h1;
    dev(1'h1, hbmp_pkg::REG_STAT, 8'h00, q);
    chk(8'h72, 8'hFF, q);
    dev(1'h0, hbmp_pkg::REG_STAT, 8'h07, q);
    dev(1'h1, hbmp_pkg::REG_STAT, 8'h00, q);
    chk(8'h70, 8'hFF, q);
    $display("test registers done");
    // Masked, then unmasked, then cleared interrupt source
    dev(1'h0, hbmp_pkg::REG_MASK, 8'h00, q);
    @(posedge hclk) core_event <= 1'h1;
    @(posedge hclk) core_event <= 1'h0;
    repeat (4) @(posedge hclk);
    chk(8'h01, 8'h01, {7'h0, hbmp_if_i.irq_n});
    dev(1'h0, hbmp_pkg::REG_MASK, 8'h04, q);
    repeat (2) @(posedge hclk);
    chk(8'h00, 8'h01, {7'h0, hbmp_if_i.irq_n});
    dev(1'h0, hbmp_pkg::REG_STAT, 8'h04, q);
    repeat (2) @(posedge hclk);
    chk(8'h01, 8'h01, {7'h0, hbmp_if_i.irq_n});
    $display("test interrupt done");
    // Normal send, backplane clock, push-pull and open-drain sends
    tx(8'($urandom) | 8'h01, 1'h0, 1'h0, 1'h0);
    dev(1'h0, hbmp_pkg::REG_CTRL, 8'h01, q);
    n = 0;
    p = hbmp_if_i.pb;
    repeat (200) begin
      @(posedge hclk);
      if (p === 1'h1 && hbmp_if_i.pb === 1'h0) n++;
      p = hbmp_if_i.pb;
    end
    chk(8'h14, 8'hFF, 8'(n));
    tx((8'($urandom) | 8'h01) & 8'h7F, 1'h1, 1'h0, 1'h0);
    dev(1'h0, hbmp_pkg::REG_CTRL, 8'h03, q);
    tx((8'($urandom) | 8'h01) & 8'h7F, 1'h1, 1'h1, 1'h0);
    $display("test line done");
    // Grounded strap: active-high enable only in backplane mode
    do_reset(1'h1);
    chk(8'h01, 8'h01, {7'h0, hbmp_if_i.txen});
    dev(1'h0, hbmp_pkg::REG_CTRL, 8'h01, q);
    repeat (2) @(posedge hclk);
    chk(8'h00, 8'h01, {7'h0, hbmp_if_i.txen});
    tx((8'($urandom) | 8'h01) & 8'h7F, 1'h1, 1'h0, 1'h1);
    $display("test strap done");
    close_out();
  end
endmodule
